// [include/hbr_pkg.sv]
// Overview of operation
// - Scheme 00b selects fixed off-time limiting, 01b selects cycle-by-cycle limiting.
// - Scheme 10b and 11b mean voltage or speed regulation; no limiting here.
// - Policy 00b never limits current, whatever the stall check setting.
// - Policy 01b limits only in startup blank if stall check on, else always.
// - Policy with upper bit set limits current at all times.
// - Trip when sensed-current voltage is at or above the trip reference.
// - Internal reference bit set selects the fixed 500 mV trip comparator.
// - Ignore trip during switch blanking; trip must persist through deglitch interval.
// - Fixed off-time trip brakes with both low sides on for the off interval.
// - After off interval, follow commands; if still tripped, start another interval.
// - Any control input change during off interval cancels it; follow inputs.
// - Fixed off-time re-enables drive by itself, working at full duty.
// - Cycle-by-cycle trip brakes until pin edge or register bit rising.
// - Cycle-by-cycle with report bit set pulls fault low until releasing edge or end of drive command.
// - Fault indication changes no other behaviour of the device.
// - Regulation indicator only asserts while forward or reverse drive is commanded.
// - Sense output disables together with a command that turns low sides off.
// - Sense valid a delay after low-side enable; continuous across drive and brake.
// - Soft bridge select 0b takes pin inputs, 1b takes register bits.
// - Inputs 10 forward, 01 reverse, 00 coast high-Z, 11 brake low sides.
package hbr_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CW = 16;

    localparam logic [AW-1:0] CTRL_ADDR   = 8'h00;
    localparam logic [AW-1:0] SOFT_ADDR   = 8'h04;
    localparam logic [AW-1:0] STATUS_ADDR = 8'h08;

    // Control register fields
    localparam int SCHEME_LSB = 0;
    localparam int POLICY_LSB = 2;
    localparam int STALL_BIT  = 4;
    localparam int INTREF_BIT = 5;
    localparam int REPORT_BIT = 6;
    localparam int SOFTSEL_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] SOFT_RESET = 2'h0;

    // Status register fields
    localparam int ST_REG_BIT   = 0;
    localparam int ST_EVENT_BIT = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_TRIP_BIT  = 3;
    localparam int ST_SENSE_BIT = 4;

    localparam logic [1:0] SCHEME_FIXED = 2'h0;
    localparam logic [1:0] SCHEME_CBC   = 2'h1;
    localparam logic [1:0] POLICY_NONE  = 2'h0;
    localparam logic [1:0] POLICY_START = 2'h1;

    // Default interval lengths in clock cycles
    localparam int OFF_CYC_DEF   = 100;
    localparam int BLANK_CYC_DEF = 25;
    localparam int DEG_CYC_DEF   = 4;
    localparam int DLY_CYC_DEF   = 50;

    typedef enum logic [1:0] {
        HBR_ST_RUN,
        HBR_ST_OFF,
        HBR_ST_CBC
    } hbr_state_e;

    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } hbr_bridge_s;

    localparam hbr_bridge_s BR_COAST = 4'h0;
    localparam hbr_bridge_s BR_FWD   = 4'h9;
    localparam hbr_bridge_s BR_REV   = 4'h6;
    localparam hbr_bridge_s BR_BRAKE = 4'h5;
endpackage

// [design/hbr_current_reg.sv]
`timescale 1ns/1ps
module hbr_current_reg #(
    parameter int OFF_CYC   = hbr_pkg::OFF_CYC_DEF,
    parameter int BLANK_CYC = hbr_pkg::BLANK_CYC_DEF,
    parameter int DEG_CYC   = hbr_pkg::DEG_CYC_DEF,
    parameter int DLY_CYC   = hbr_pkg::DLY_CYC_DEF
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    arst_n_in,
    // Register port
    input  wire logic [hbr_pkg::AW-1:0]  reg_addr_in,
    input  wire logic [hbr_pkg::DW-1:0]  reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic [hbr_pkg::DW-1:0]       reg_rdata_out,
    // Bridge control pins
    input  wire logic                    bridge_input_one_in,
    input  wire logic                    bridge_input_two_in,
    // Comparators and startup window
    input  wire logic                    trip_cmp_ext_in,
    input  wire logic                    trip_cmp_int_in,
    input  wire logic                    startup_blank_in,
    // Bridge drive and status
    output hbr_pkg::hbr_bridge_s         bridge_out,
    output logic                         sense_enable_out,
    output logic                         sense_ready_out,
    output logic                         fault_flag_n_out
);
    localparam int CW = hbr_pkg::CW;
    localparam logic [CW-1:0] OFF_N   = CW'(OFF_CYC);
    localparam logic [CW-1:0] BLANK_N = CW'(BLANK_CYC);
    localparam logic [CW-1:0] DEG_N   = CW'(DEG_CYC);
    localparam logic [CW-1:0] DLY_N   = CW'(DLY_CYC);
    localparam logic [CW-1:0] ONE     = CW'(1);

    logic [7:0]                ctrl_r;
    logic [1:0]                soft_r;
    logic [1:0]                soft_prev_r;
    logic [4:0]                sync1_r;
    logic [4:0]                sync2_r;
    logic [1:0]                pin_prev_r;
    logic [1:0]                cmd_prev_r;
    logic [CW-1:0]             blank_cnt_r;
    logic [CW-1:0]             deg_cnt_r;
    logic [CW-1:0]             off_cnt_r;
    logic [CW-1:0]             sense_cnt_r;
    hbr_pkg::hbr_state_e       state_r;
    hbr_pkg::hbr_state_e       state_nxt;
    hbr_pkg::hbr_bridge_s      bridge_r;
    hbr_pkg::hbr_bridge_s      bridge_nxt;
    logic                      fault_n_r;
    logic                      sense_en_r;
    logic                      sense_ready_r;
    logic [hbr_pkg::DW-1:0]    rdata_r;

    logic [1:0]                scheme;
    logic [1:0]                policy;
    logic [1:0]                pins;
    logic [1:0]                cmd;
    logic                      trip_raw;
    logic                      blanked;
    logic                      trip_q;
    logic                      limit_on;
    logic                      drive_cmd;
    logic                      cmd_change;
    logic                      release_edge;
    logic                      off_load;
    logic                      sense_en_nxt;

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    assign scheme   = ctrl_r[hbr_pkg::SCHEME_LSB +: 2];
    assign policy   = ctrl_r[hbr_pkg::POLICY_LSB +: 2];
    assign pins     = sync2_r[1:0];

    // Pin and comparator synchronisers
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {startup_blank_in, trip_cmp_int_in, trip_cmp_ext_in,
                        bridge_input_two_in, bridge_input_one_in};
            sync2_r <= sync1_r;
        end
    end

    // Register writes
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_r <= hbr_pkg::CTRL_RESET;
            soft_r <= hbr_pkg::SOFT_RESET;
        end else if (reg_wr_in) begin
            if (reg_addr_in == hbr_pkg::CTRL_ADDR) begin
                ctrl_r <= reg_wdata_in[7:0];
            end
            if (reg_addr_in == hbr_pkg::SOFT_ADDR) begin
                soft_r <= reg_wdata_in[1:0];
            end
        end
    end

    // Register reads, data valid the cycle after the strobe only
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    hbr_pkg::CTRL_ADDR: begin
                        rdata_r[7:0] <= ctrl_r;
                    end
                    hbr_pkg::SOFT_ADDR: begin
                        rdata_r[1:0] <= soft_r;
                    end
                    hbr_pkg::STATUS_ADDR: begin
                        rdata_r[hbr_pkg::ST_REG_BIT]   <= (state_r != hbr_pkg::HBR_ST_RUN);
                        rdata_r[hbr_pkg::ST_EVENT_BIT] <= ~fault_n_r;
                        rdata_r[hbr_pkg::ST_READY_BIT] <= sense_ready_r;
                        rdata_r[hbr_pkg::ST_TRIP_BIT]  <= trip_q;
                        rdata_r[hbr_pkg::ST_SENSE_BIT] <= sense_en_r;
                    end
                    default: begin
                        rdata_r <= '0;
                    end
                endcase
            end
        end
    end

    // Command source and edge history
    assign cmd = ctrl_r[hbr_pkg::SOFTSEL_BIT] ? soft_r : pins;
    assign drive_cmd  = cmd[0] ^ cmd[1];
    assign cmd_change = (cmd != cmd_prev_r);
    // Soft bits release only on a rising bit, pins on any edge
    assign release_edge = ctrl_r[hbr_pkg::SOFTSEL_BIT] ?
                          |(soft_r & ~soft_prev_r) : (pins != pin_prev_r);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_prev_r  <= 2'h0;
            soft_prev_r <= 2'h0;
            cmd_prev_r  <= 2'h0;
        end else begin
            pin_prev_r  <= pins;
            soft_prev_r <= soft_r;
            cmd_prev_r  <= cmd;
        end
    end

    // Trip detection
    assign trip_raw = ctrl_r[hbr_pkg::INTREF_BIT] ? sync2_r[3] : sync2_r[2];
    assign blanked  = (blank_cnt_r != '0);
    // Gated so a trip counted before a switch cannot act inside the fresh blank
    assign trip_q   = (deg_cnt_r == DEG_N) && !blanked;

    // Blanking restarts on every change of the bridge pattern
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blank_cnt_r <= '0;
        end else if (bridge_nxt != bridge_r) begin
            blank_cnt_r <= BLANK_N;
        end else if (blanked) begin
            blank_cnt_r <= blank_cnt_r - ONE;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            deg_cnt_r <= '0;
        end else if (!trip_raw || blanked) begin
            deg_cnt_r <= '0;
        end else if (!trip_q) begin
            deg_cnt_r <= deg_cnt_r + ONE;
        end
    end

    // When limiting is allowed at all
    always_comb begin
        limit_on = 1'b0;
        if (!scheme[1]) begin
            if (policy[1]) begin
                limit_on = 1'b1;
            end else if (policy == hbr_pkg::POLICY_START) begin
                limit_on = ctrl_r[hbr_pkg::STALL_BIT] ? sync2_r[4] : 1'b1;
            end else begin
                limit_on = 1'b0;
            end
        end
    end

    // Regulation state
    always_comb begin
        state_nxt = state_r;
        off_load  = 1'b0;
        case (state_r)
            hbr_pkg::HBR_ST_RUN: begin
                if (limit_on && drive_cmd && trip_q) begin
                    if (scheme == hbr_pkg::SCHEME_FIXED) begin
                        state_nxt = hbr_pkg::HBR_ST_OFF;
                        off_load  = 1'b1;
                    end else begin
                        state_nxt = hbr_pkg::HBR_ST_CBC;
                    end
                end
            end
            hbr_pkg::HBR_ST_OFF: begin
                if (cmd_change) begin
                    state_nxt = hbr_pkg::HBR_ST_RUN;
                end else if (off_cnt_r <= ONE) begin
                    if (trip_raw) begin
                        off_load = 1'b1;
                    end else begin
                        state_nxt = hbr_pkg::HBR_ST_RUN;
                    end
                end
            end
            hbr_pkg::HBR_ST_CBC: begin
                if (release_edge) begin
                    state_nxt = hbr_pkg::HBR_ST_RUN;
                end
            end
            default: begin
                state_nxt = hbr_pkg::HBR_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= hbr_pkg::HBR_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            off_cnt_r <= '0;
        end else if (off_load) begin
            off_cnt_r <= OFF_N;
        end else if (off_cnt_r != '0) begin
            off_cnt_r <= off_cnt_r - ONE;
        end
    end

    // Bridge pattern: brake while regulating, else the truth table
    always_comb begin
        if (state_nxt != hbr_pkg::HBR_ST_RUN) begin
            bridge_nxt = hbr_pkg::BR_BRAKE;
        end else begin
            case (cmd)
                2'h1:    bridge_nxt = hbr_pkg::BR_FWD;
                2'h2:    bridge_nxt = hbr_pkg::BR_REV;
                2'h3:    bridge_nxt = hbr_pkg::BR_BRAKE;
                default: bridge_nxt = hbr_pkg::BR_COAST;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bridge_r <= hbr_pkg::BR_COAST;
        end else begin
            bridge_r <= bridge_nxt;
        end
    end

    // Regulation indicator; drives the fault output and the status event bit
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_n_r <= 1'b1;
        end else if (state_r == hbr_pkg::HBR_ST_RUN && state_nxt == hbr_pkg::HBR_ST_CBC &&
                     ctrl_r[hbr_pkg::REPORT_BIT]) begin
            fault_n_r <= 1'b0;
        end else if (release_edge || !drive_cmd) begin
            fault_n_r <= 1'b1;
        end
    end

    // Sense follows the low sides in the same cycle as the command
    assign sense_en_nxt = bridge_nxt.ls1 | bridge_nxt.ls2;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sense_cnt_r <= '0;
        end else if (!sense_en_nxt) begin
            sense_cnt_r <= '0;
        end else if (sense_cnt_r != DLY_N) begin
            sense_cnt_r <= sense_cnt_r + ONE;
        end
    end

    // Drive to brake keeps a low side on, so the count never restarts
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sense_en_r    <= 1'b0;
            sense_ready_r <= 1'b0;
        end else begin
            sense_en_r    <= sense_en_nxt;
            sense_ready_r <= sense_en_nxt && (sense_cnt_r == DLY_N);
        end
    end

    assign reg_rdata_out    = rdata_r;
    assign bridge_out       = bridge_r;
    assign sense_enable_out = sense_en_r;
    assign sense_ready_out  = sense_ready_r;
    assign fault_flag_n_out = fault_n_r;

    a_policy_none_idle: assert property (
        (policy == hbr_pkg::POLICY_NONE && !scheme[1] && state_r == hbr_pkg::HBR_ST_RUN)
        |=> state_r == hbr_pkg::HBR_ST_RUN)
        else $error("Limiting entered with policy off");

    a_voltage_mode_idle: assert property (
        (scheme[1] && state_r == hbr_pkg::HBR_ST_RUN) |=> state_r == hbr_pkg::HBR_ST_RUN)
        else $error("Limiting entered in voltage or speed mode");

    a_scheme_picks_state: assert property (
        (state_r == hbr_pkg::HBR_ST_RUN && state_nxt != hbr_pkg::HBR_ST_RUN)
        |=> (state_r == hbr_pkg::HBR_ST_OFF) == ($past(scheme) == hbr_pkg::SCHEME_FIXED))
        else $error("Wrong regulation scheme entered");

    a_entry_deglitched: assert property (
        (state_r == hbr_pkg::HBR_ST_RUN && state_nxt != hbr_pkg::HBR_ST_RUN)
        |-> deg_cnt_r == DEG_N && !blanked && drive_cmd && limit_on)
        else $error("Regulation entered without qualified trip");

    a_brake_while_reg: assert property (
        state_r != hbr_pkg::HBR_ST_RUN |-> bridge_r == hbr_pkg::BR_BRAKE)
        else $error("Bridge not braking during regulation");

    a_off_cancel: assert property (
        (state_r == hbr_pkg::HBR_ST_OFF && cmd_change) |=> state_r == hbr_pkg::HBR_ST_RUN)
        else $error("Off interval not cancelled by input change");

    a_off_length: assert property (
        (state_r == hbr_pkg::HBR_ST_RUN ##1 state_r == hbr_pkg::HBR_ST_OFF)
        |-> off_cnt_r == OFF_N)
        else $error("Off interval loaded with wrong length");

    a_cbc_hold: assert property (
        (state_r == hbr_pkg::HBR_ST_CBC && !release_edge) |=> state_r == hbr_pkg::HBR_ST_CBC)
        else $error("Brake released without control edge");

    a_report_entry: assert property (
        (state_r == hbr_pkg::HBR_ST_RUN && state_nxt == hbr_pkg::HBR_ST_CBC &&
         ctrl_r[hbr_pkg::REPORT_BIT]) |=> !fault_n_r)
        else $error("Regulation entry not reported");

    a_fault_drive_only: assert property (
        !fault_n_r |-> $past(drive_cmd))
        else $error("Indicator low outside drive command");

    a_sense_cut: assert property (
        (cmd == 2'h0 && state_nxt == hbr_pkg::HBR_ST_RUN) |=> !sense_en_r)
        else $error("Sense still enabled after coast command");

    a_off_resume: assert property (
        (state_r == hbr_pkg::HBR_ST_OFF && off_cnt_r == ONE && !trip_raw && !cmd_change)
        |=> state_r == hbr_pkg::HBR_ST_RUN && bridge_r != hbr_pkg::BR_BRAKE)
        else $error("Drive not restored after off interval");

    c_fixed_off: cover property (state_r == hbr_pkg::HBR_ST_RUN ##1 state_r == hbr_pkg::HBR_ST_OFF);
    c_off_again: cover property (state_r == hbr_pkg::HBR_ST_OFF && off_load);
    c_cbc_entry: cover property (state_r == hbr_pkg::HBR_ST_RUN ##1 state_r == hbr_pkg::HBR_ST_CBC);
    c_report_low: cover property ($fell(fault_n_r));
    c_cbc_release: cover property (state_r == hbr_pkg::HBR_ST_CBC ##1 state_r == hbr_pkg::HBR_ST_RUN);
endmodule

// [sim/hbr_mcu_model.sv]
`timescale 1ns/1ps
module hbr_mcu_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Bench commands
    input  wire logic [1:0] cmd_in,
    input  wire logic       restore_in,
    // Device side
    input  wire logic       fault_flag_n_in,
    output logic            bridge_input_one_out,
    output logic            bridge_input_two_out,
    output logic            real_fault_out
);
    logic [1:0] pins_r;
    logic [1:0] pins_nxt;
    logic [3:0] stable_r;

    assign pins_nxt             = restore_in ? 2'h0 : cmd_in;
    assign bridge_input_one_out = pins_r[0];
    assign bridge_input_two_out = pins_r[1];

    // A short coast gap gives a fresh edge; steady full duty never frees the brake
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pins_r <= 2'h0;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // Judged only once the pins have passed sync and output update
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stable_r <= 4'h0;
        end else if (pins_nxt != pins_r) begin
            stable_r <= 4'h0;
        end else if (stable_r != 4'hf) begin
            stable_r <= stable_r + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            real_fault_out <= 1'b0;
        end else if (stable_r > 4'h7 && !fault_flag_n_in && pins_r[0] == pins_r[1]) begin
            real_fault_out <= 1'b1;
        end
    end
endmodule

// [sim/tb_hbr_current_reg.sv]
`timescale 1ns/1ps
module tb_hbr_current_reg;
    localparam int OFF = 8;
    localparam int BLK = 3;
    localparam int DEG = 2;
    localparam int DLY = 4;
    logic                   clk_in    = 1'b0;
    logic                   arst_n_in = 1'b0;
    logic [hbr_pkg::AW-1:0] addr      = '0;
    logic [hbr_pkg::DW-1:0] wdata     = '0;
    logic                   wr        = 1'b0;
    logic                   rd        = 1'b0;
    logic [hbr_pkg::DW-1:0] rdata;
    logic                   ext       = 1'b0;
    logic                   intc      = 1'b0;
    logic                   startup   = 1'b0;
    logic [1:0]             cmd       = 2'h0;
    logic                   restore   = 1'b0;
    logic                   pin1;
    logic                   pin2;
    hbr_pkg::hbr_bridge_s   br;
    logic                   sen;
    logic                   srdy;
    logic                   fault_n;
    logic                   real_fault;
    logic                   seen      = 1'b0;
    logic [31:0]            d;
    int                     bad_count = 0;
    int                     cmp_count = 0;
    // Trip table: control byte, use internal comparator, startup window, pulse, expect brake
    logic [7:0]             tc [12]   = '{8'h08, 8'h08, 8'h00, 8'h10, 8'h04, 8'h14, 8'h14, 8'h0a, 8'h0b,
                                          8'h28, 8'h28, 8'h0c};
    logic                   ti [12]   = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0};
    logic                   ts [12]   = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0};
    int                     tp [12]   = '{10, 1, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10};
    logic                   te [12]   = '{1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1, 1};

    always #2 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (br === hbr_pkg::BR_BRAKE) begin
            seen <= 1'b1;
        end
    end

    // Short counts keep the run brief
    hbr_current_reg #(.OFF_CYC(OFF), .BLANK_CYC(BLK), .DEG_CYC(DEG), .DLY_CYC(DLY)) hbr_current_reg_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .bridge_input_one_in(pin1), .bridge_input_two_in(pin2),
        .trip_cmp_ext_in(ext), .trip_cmp_int_in(intc), .startup_blank_in(startup),
        .bridge_out(br), .sense_enable_out(sen), .sense_ready_out(srdy), .fault_flag_n_out(fault_n));

    hbr_mcu_model hbr_mcu_model_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_in(cmd), .restore_in(restore),
        .fault_flag_n_in(fault_n), .bridge_input_one_out(pin1), .bridge_input_two_out(pin2),
        .real_fault_out(real_fault));

    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_br(input hbr_pkg::hbr_bridge_s got, input hbr_pkg::hbr_bridge_s exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    task automatic wait_br(input hbr_pkg::hbr_bridge_s exp, input int max);
        int n;
        n = 0;
        while (br !== exp) begin
            if (n == max) begin
                chk_br(br, exp);
                summarize();
            end
            cyc(1);
            n++;
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic set_cmd(input logic [1:0] v);
        @(posedge clk_in);
        cmd <= v;
    endtask

    task automatic trip_hit();
        cyc(12);
        @(posedge clk_in);
        ext <= 1'b1;
        wait_br(hbr_pkg::BR_BRAKE, 12);
        @(posedge clk_in);
        ext <= 1'b0;
    endtask

    task automatic t_reset();
        chk_br(br, hbr_pkg::BR_COAST);
        chk32(fault_n, 32'h1);
        rreg(hbr_pkg::CTRL_ADDR, d);
        chk32(d, 32'h0);
        rreg(hbr_pkg::SOFT_ADDR, d);
        chk32(d, 32'h0);
        rreg(hbr_pkg::STATUS_ADDR, d);
        chk32(d, 32'h0);
        wreg(8'h0c, 32'hffff_ffff);
        rreg(8'h0c, d);
        chk32(d, 32'h0);
        wreg(hbr_pkg::CTRL_ADDR, 32'h5a);
        rreg(hbr_pkg::CTRL_ADDR, d);
        chk32(d, 32'h5a);
        wreg(hbr_pkg::CTRL_ADDR, 32'h0);
    endtask

    task automatic t_table();
        hbr_pkg::hbr_bridge_s exp [4];
        exp = '{hbr_pkg::BR_COAST, hbr_pkg::BR_FWD, hbr_pkg::BR_REV, hbr_pkg::BR_BRAKE};
        for (int i = 0; i < 4; i++) begin
            set_cmd(2'(i));
            wait_br(exp[i], 6);
            chk_br(br, exp[i]);
        end
        // Pins held opposite so a wrong source selection shows
        wreg(hbr_pkg::CTRL_ADDR, 32'h80);
        for (int i = 0; i < 4; i++) begin
            set_cmd(~2'(i));
            wreg(hbr_pkg::SOFT_ADDR, 32'(i));
            wait_br(exp[i], 6);
            chk_br(br, exp[i]);
        end
        wreg(hbr_pkg::SOFT_ADDR, 32'h0);
        wreg(hbr_pkg::CTRL_ADDR, 32'h0);
        set_cmd(2'h0);
    endtask

    task automatic t_trips();
        for (int i = 0; i < 12; i++) begin
            wreg(hbr_pkg::CTRL_ADDR, {24'h0, tc[i]});
            startup <= ts[i];
            set_cmd(2'h1);
            cyc(12);
            seen = 1'b0;
            @(posedge clk_in);
            ext  <= ~ti[i];
            intc <= ti[i];
            repeat (tp[i]) @(posedge clk_in);
            ext  <= 1'b0;
            intc <= 1'b0;
            cyc(24);
            chk32(seen, te[i]);
            set_cmd(2'h0);
            cyc(8);
        end
        startup <= 1'b0;
    endtask

    task automatic t_fixed();
        int n;
        wreg(hbr_pkg::CTRL_ADDR, 32'h08);
        set_cmd(2'h1);
        trip_hit();
        n = 1;
        while (br === hbr_pkg::BR_BRAKE && n < 3 * OFF) begin
            cyc(1);
            n++;
        end
        chk32(n, OFF);
        chk_br(br, hbr_pkg::BR_FWD);
        cyc(12);
        @(posedge clk_in);
        ext <= 1'b1;
        wait_br(hbr_pkg::BR_BRAKE, 12);
        cyc(3 * OFF);
        chk_br(br, hbr_pkg::BR_BRAKE);
        @(posedge clk_in);
        ext <= 1'b0;
        wait_br(hbr_pkg::BR_FWD, OFF + 4);
        chk_br(br, hbr_pkg::BR_FWD);
        trip_hit();
        cmd <= 2'h2;
        wait_br(hbr_pkg::BR_REV, 5);
        chk_br(br, hbr_pkg::BR_REV);
        set_cmd(2'h0);
        cyc(8);
    endtask

    task automatic t_cbc();
        wreg(hbr_pkg::CTRL_ADDR, 32'h49);
        set_cmd(2'h1);
        trip_hit();
        cyc(2);
        chk32(fault_n, 32'h0);
        // Regulating, event, sense ready and sense enabled; trip already gone
        rreg(hbr_pkg::STATUS_ADDR, d);
        chk32(d, 32'h17);
        cyc(3 * OFF);
        chk_br(br, hbr_pkg::BR_BRAKE);
        @(posedge clk_in);
        restore <= 1'b1;
        @(posedge clk_in);
        restore <= 1'b0;
        wait_br(hbr_pkg::BR_FWD, 10);
        chk_br(br, hbr_pkg::BR_FWD);
        chk32(fault_n, 32'h1);
        // A falling soft bit must not release the brake
        wreg(hbr_pkg::CTRL_ADDR, 32'hc9);
        wreg(hbr_pkg::SOFT_ADDR, 32'h1);
        trip_hit();
        wreg(hbr_pkg::SOFT_ADDR, 32'h0);
        set_cmd(2'h0);
        cyc(6);
        chk_br(br, hbr_pkg::BR_BRAKE);
        chk32(fault_n, 32'h1);
        wreg(hbr_pkg::SOFT_ADDR, 32'h1);
        set_cmd(2'h1);
        wait_br(hbr_pkg::BR_FWD, 8);
        chk_br(br, hbr_pkg::BR_FWD);
        wreg(hbr_pkg::SOFT_ADDR, 32'h0);
        wreg(hbr_pkg::CTRL_ADDR, 32'h0);
        set_cmd(2'h0);
        cyc(8);
    endtask

    task automatic t_sense();
        set_cmd(2'h1);
        wait_br(hbr_pkg::BR_FWD, 6);
        chk32(sen, 32'h1);
        cyc(DLY - 1);
        chk32(srdy, 32'h0);
        cyc(1);
        chk32(srdy, 32'h1);
        set_cmd(2'h3);
        wait_br(hbr_pkg::BR_BRAKE, 6);
        chk32(srdy, 32'h1);
        set_cmd(2'h1);
        wait_br(hbr_pkg::BR_FWD, 6);
        chk32(srdy, 32'h1);
        set_cmd(2'h0);
        wait_br(hbr_pkg::BR_COAST, 6);
        chk32({sen, srdy}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        arst_n_in <= 1'b1;
        cyc(2);
        t_reset();
        t_table();
        t_trips();
        t_fixed();
        t_cbc();
        t_sense();
        chk32(real_fault, 32'h0);
        summarize();
    end
endmodule
